// [verilog/cms_regs.svh]
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// -----------------------------------------------------------------------------
// Strap codes for the eight clock operating modes
// -----------------------------------------------------------------------------
`define CMS_MODE_EXT_SHAPED   3'h0
`define CMS_MODE_XTAL_X4      3'h1
`define CMS_MODE_BUS_INPUT    3'h2
`define CMS_MODE_XTAL_X1      3'h3
`define CMS_MODE_EXT_LOWPWR   3'h4
`define CMS_MODE_EXT_HALF     3'h5
`define CMS_MODE_RTC_HIGH     3'h6
`define CMS_MODE_RTC_LOW      3'h7
`define CMS_MODE_W            3

// -----------------------------------------------------------------------------
// Multiplier and divider selection codes (x1, x2, x4 and 1, 1/2, 1/4)
// -----------------------------------------------------------------------------
`define CMS_CODE_X1           2'h0
`define CMS_CODE_X2           2'h1
`define CMS_CODE_X4           2'h2
`define CMS_FACTOR_1          3'h1
`define CMS_FACTOR_2          3'h2
`define CMS_FACTOR_4          3'h4

// -----------------------------------------------------------------------------
// Low-frequency loop input and target frequencies in Hz
// -----------------------------------------------------------------------------
`define CMS_RTC_XTAL_HZ       24'h008000
`define CMS_RTC_HIGH_HZ       24'he10000
`define CMS_RTC_LOW_HZ        24'ha90010
`define CMS_HZ_NONE           24'h000000

// -----------------------------------------------------------------------------
// Synchroniser
// -----------------------------------------------------------------------------
`define CMS_SYNC_STAGES       2
`define CMS_SYNC_W            7

`endif

// [verilog/cms_pkg.sv]
`default_nettype none

package cms_pkg;

    // Clock source picked by the mode straps.
    typedef enum logic [2:0] {
        CMS_SRC_OFF,
        CMS_SRC_EXT,
        CMS_SRC_XTAL,
        CMS_SRC_BUS,
        CMS_SRC_RTC
    } cms_src_type;

    // Start-up sequencer states.
    typedef enum logic [1:0] {
        CMS_ST_FILL0,
        CMS_ST_FILL1,
        CMS_ST_FILL2,
        CMS_ST_RUN
    } cms_state_type;

endpackage

`default_nettype wire

// [verilog/cms_half_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Carrier between the mode decoder and the half-rate divider.
interface cms_half_if;
    logic enable;
    logic extLevel;
    logic halfLevel;

    modport ctrl (output enable, output extLevel, input halfLevel);
    modport div  (input enable, input extLevel, output halfLevel);
endinterface

`default_nettype wire

// [verilog/cms_half_divider.sv]
`timescale 1ns/1ps
`default_nettype none

module cms_half_divider (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    cms_half_if.div   half
);

    logic extPrev_r;
    logic half_r;

    // -------------------------------------------------------------------------
    // Edge tracking of the already synchronised external level
    // -------------------------------------------------------------------------
    // Edge history of the external level.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= half.extLevel;
        end
    end

    // Toggling once per rising edge gives half the rate and an even duty cycle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            half_r <= 1'b0;
        end else if (!half.enable) begin
            half_r <= 1'b0;
        end else if (half.extLevel && !extPrev_r) begin
            half_r <= ~half_r;
        end
    end

    assign half.halfLevel = half_r;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    AST_HALF_TOGGLE: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (half.enable && half.extLevel && !extPrev_r) |=> (half_r != $past(half_r))
    ) else $error("Half-rate divider missed a toggle.");

    AST_HALF_HOLD: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (half.enable && !(half.extLevel && !extPrev_r)) ##1 half.enable |-> $stable(half_r)
    ) else $error("Half-rate divider toggled without an input edge.");

endmodule // cms_half_divider

`default_nettype wire

// [verilog/clock_mode_source_select.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cms_regs.svh"

module clock_mode_source_select
    import cms_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [2:0] clockModeStraps,
    input  wire logic       extClockInPin,
    input  wire logic       crystalClkIn,
    input  wire logic       rtcLoopClkIn,
    input  wire logic       busClockPinIn,
    output logic            busClockPinOut,
    output logic            busClockPinOe,
    input  wire logic       mainLoopOnReq,
    input  wire logic [1:0] mainLoopMultSel,
    input  wire logic [1:0] coreDivSel,
    output logic            modeValid,
    output logic [2:0]      clockMode,
    output logic [2:0]      srcSel,
    output logic            crystalOscEn,
    output logic            shapingLoopEn,
    output logic [2:0]      shapingLoopMult,
    output logic            rtcLoopEn,
    output logic [23:0]     rtcLoopTargetHz,
    output logic            halfDivEn,
    output logic            mainLoopEn,
    output logic [2:0]      mainLoopMult,
    output logic [1:0]      coreDivRatio,
    output logic            coreDivSrcLoop,
    output logic            periphDivSrcLoop,
    output logic            srcClkLevel
);

    // -------------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------------
    // Source clock for a given mode; used by the decoder and the checks.
    function automatic cms_src_type srcOf(input logic [2:0] mode);
        cms_src_type s;
        s = CMS_SRC_EXT;
        if (mode == `CMS_MODE_XTAL_X4 || mode == `CMS_MODE_XTAL_X1) begin
            s = CMS_SRC_XTAL;
        end else if (mode == `CMS_MODE_BUS_INPUT) begin
            s = CMS_SRC_BUS;
        end else if (mode == `CMS_MODE_RTC_HIGH || mode == `CMS_MODE_RTC_LOW) begin
            s = CMS_SRC_RTC;
        end
        return s;
    endfunction

    // Modes 0 to 2 keep the main loop on for good; the rest let software choose.
    function automatic logic loopFixedOn(input logic [2:0] mode);
        return (mode <= `CMS_MODE_BUS_INPUT);
    endfunction

    // Code to multiplication factor; an unused code falls back to x1.
    function automatic logic [2:0] factorOf(input logic [1:0] code);
        logic [2:0] f;
        f = `CMS_FACTOR_1;
        if (code == `CMS_CODE_X2) begin
            f = `CMS_FACTOR_2;
        end else if (code == `CMS_CODE_X4) begin
            f = `CMS_FACTOR_4;
        end
        return f;
    endfunction

    // -------------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------------
    logic [`CMS_SYNC_W-1:0] pinRaw;
    logic [`CMS_SYNC_W-1:0] syncStage1_r;
    logic [`CMS_SYNC_W-1:0] syncStage2_r;

    assign pinRaw = {clockModeStraps, extClockInPin, crystalClkIn, rtcLoopClkIn, busClockPinIn};

    // Every pin passes two flops; the first stage feeds only the second.
    generate
        for (genvar i = 0; i < `CMS_SYNC_W; i++) begin : gSync
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    syncStage1_r[i] <= 1'b0;
                    syncStage2_r[i] <= 1'b0;
                end else begin
                    syncStage1_r[i] <= pinRaw[i];
                    syncStage2_r[i] <= syncStage1_r[i];
                end
            end
        end
    endgenerate

    logic [2:0] strapSync;
    logic       extSync;
    logic       xtalSync;
    logic       rtcSync;
    logic       busInSync;

    assign strapSync = syncStage2_r[6:4];
    assign extSync   = syncStage2_r[3];
    assign xtalSync  = syncStage2_r[2];
    assign rtcSync   = syncStage2_r[1];
    assign busInSync = syncStage2_r[0];

    // -------------------------------------------------------------------------
    // Start-up sequencer and strap latch
    // -------------------------------------------------------------------------
    cms_state_type state_r;
    cms_state_type state_nxt;
    logic          latchNow;
    logic [2:0]    mode_r;
    logic [2:0]    mode_nxt;

    // The straps are caught only once the synchroniser has filled after reset.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CMS_ST_FILL0: state_nxt = CMS_ST_FILL1;
            CMS_ST_FILL1: state_nxt = CMS_ST_FILL2;
            CMS_ST_FILL2: state_nxt = CMS_ST_RUN;
            CMS_ST_RUN:   state_nxt = CMS_ST_RUN;
            default:      state_nxt = CMS_ST_FILL0;
        endcase
    end

    // Two idle edges let the second stage hold the pin level, not its reset zero.
    assign latchNow = (state_r == CMS_ST_FILL2);
    assign mode_nxt = latchNow ? strapSync : mode_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= CMS_ST_FILL0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Strap changes after the latch are ignored until the next reset.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= `CMS_MODE_EXT_SHAPED;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Mode decode into clock tree controls
    // -------------------------------------------------------------------------
    logic        runNxt;
    cms_src_type src_nxt;
    logic        xtalEn_nxt;
    logic        shapeEn_nxt;
    logic [2:0]  shapeMult_nxt;
    logic        rtcEn_nxt;
    logic [23:0] rtcHz_nxt;
    logic        halfEn_nxt;
    logic        busOe_nxt;
    logic        loopOn_nxt;
    logic [1:0]  coreDiv_nxt;

    assign runNxt = (state_nxt == CMS_ST_RUN);

    // Nothing is switched on before the mode is known.
    always_comb begin
        src_nxt       = CMS_SRC_OFF;
        xtalEn_nxt    = 1'b0;
        shapeEn_nxt   = 1'b0;
        shapeMult_nxt = `CMS_FACTOR_1;
        rtcEn_nxt     = 1'b0;
        rtcHz_nxt     = `CMS_HZ_NONE;
        halfEn_nxt    = 1'b0;
        busOe_nxt     = 1'b0;
        if (runNxt) begin
            src_nxt    = srcOf(mode_nxt);
            xtalEn_nxt = (src_nxt == CMS_SRC_XTAL);
            busOe_nxt  = (mode_nxt != `CMS_MODE_BUS_INPUT);
            if (mode_nxt == `CMS_MODE_XTAL_X4) begin
                shapeEn_nxt   = 1'b1;
                shapeMult_nxt = `CMS_FACTOR_4;
            end else if (mode_nxt == `CMS_MODE_EXT_SHAPED || mode_nxt == `CMS_MODE_XTAL_X1 ||
                         mode_nxt == `CMS_MODE_EXT_LOWPWR) begin
                shapeEn_nxt = 1'b1;
            end else if (mode_nxt == `CMS_MODE_EXT_HALF) begin
                halfEn_nxt = 1'b1;
            end else if (mode_nxt == `CMS_MODE_RTC_HIGH) begin
                rtcEn_nxt = 1'b1;
                rtcHz_nxt = `CMS_RTC_HIGH_HZ;
            end else if (mode_nxt == `CMS_MODE_RTC_LOW) begin
                rtcEn_nxt = 1'b1;
                rtcHz_nxt = `CMS_RTC_LOW_HZ;
            end
        end
    end

    // Main loop: fixed on in modes 0-2, off after latch otherwise, then software's.
    always_comb begin
        loopOn_nxt = 1'b0;
        if (latchNow) begin
            loopOn_nxt = loopFixedOn(mode_nxt);
        end else if (state_r == CMS_ST_RUN) begin
            loopOn_nxt = loopFixedOn(mode_r) || mainLoopOnReq;
        end
    end

    // The core divider may never divide more than the loop multiplies.
    always_comb begin
        coreDiv_nxt = coreDivSel;
        if (coreDivSel > `CMS_CODE_X4) begin
            coreDiv_nxt = `CMS_CODE_X1;
        end
        if (!loopOn_nxt) begin
            coreDiv_nxt = `CMS_CODE_X1;
        end else if (mainLoopMultSel > `CMS_CODE_X4) begin
            coreDiv_nxt = `CMS_CODE_X1;
        end else if (coreDiv_nxt > mainLoopMultSel) begin
            coreDiv_nxt = mainLoopMultSel;
        end
    end

    // -------------------------------------------------------------------------
    // Registered control outputs
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            modeValid       <= 1'b0;
            clockMode       <= `CMS_MODE_EXT_SHAPED;
            srcSel          <= CMS_SRC_OFF;
            crystalOscEn    <= 1'b0;
            shapingLoopEn   <= 1'b0;
            shapingLoopMult <= `CMS_FACTOR_1;
            rtcLoopEn       <= 1'b0;
            rtcLoopTargetHz <= `CMS_HZ_NONE;
            halfDivEn       <= 1'b0;
            busClockPinOe   <= 1'b0;
        end else begin
            modeValid       <= runNxt;
            clockMode       <= mode_nxt;
            srcSel          <= src_nxt;
            crystalOscEn    <= xtalEn_nxt;
            shapingLoopEn   <= shapeEn_nxt;
            shapingLoopMult <= shapeMult_nxt;
            rtcLoopEn       <= rtcEn_nxt;
            rtcLoopTargetHz <= rtcHz_nxt;
            halfDivEn       <= halfEn_nxt;
            busClockPinOe   <= busOe_nxt;
        end
    end

    // Loop and divider steering follows the loop state in the same cycle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mainLoopEn       <= 1'b0;
            mainLoopMult     <= `CMS_FACTOR_1;
            coreDivRatio     <= `CMS_CODE_X1;
            coreDivSrcLoop   <= 1'b0;
            periphDivSrcLoop <= 1'b0;
        end else begin
            mainLoopEn       <= loopOn_nxt;
            mainLoopMult     <= loopOn_nxt ? factorOf(mainLoopMultSel) : `CMS_FACTOR_1;
            coreDivRatio     <= coreDiv_nxt;
            coreDivSrcLoop   <= loopOn_nxt;
            periphDivSrcLoop <= loopOn_nxt && loopFixedOn(mode_nxt);
        end
    end

    // -------------------------------------------------------------------------
    // Source clock path and bus clock pin
    // -------------------------------------------------------------------------
    cms_half_if halfBus ();

    assign halfBus.enable   = halfDivEn;
    assign halfBus.extLevel = extSync;

    cms_half_divider uHalfDiv (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .half    (halfBus.div)
    );

    // Sampled source level; the real tree is analogue, this tracks its phase.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            srcClkLevel <= 1'b0;
        end else if (halfDivEn) begin
            srcClkLevel <= halfBus.halfLevel;
        end else if (srcSel == CMS_SRC_XTAL) begin
            srcClkLevel <= xtalSync;
        end else if (srcSel == CMS_SRC_RTC) begin
            srcClkLevel <= rtcSync;
        end else if (srcSel == CMS_SRC_BUS) begin
            srcClkLevel <= busInSync;
        end else if (srcSel == CMS_SRC_EXT) begin
            srcClkLevel <= extSync;
        end else begin
            srcClkLevel <= 1'b0;
        end
    end

    // Driving the level only while enabled keeps the pin quiet in mode 2.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busClockPinOut <= 1'b0;
        end else begin
            busClockPinOut <= busClockPinOe ? srcClkLevel : 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    sequence seqLatch;
        (state_r == CMS_ST_FILL2) ##1 modeValid;
    endsequence

    AST_MODE_LATCH: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state_r == CMS_ST_FILL2) |=> (clockMode == $past(strapSync) && srcSel == srcOf(clockMode))
    ) else $error("Mode not taken from the straps.");

    AST_MODE_STABLE: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        modeValid |=> (modeValid && $stable(clockMode))
    ) else $error("Latched mode changed.");

    AST_MODE0_CFG: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_EXT_SHAPED) |->
            (shapingLoopEn && shapingLoopMult == `CMS_FACTOR_1 && mainLoopEn && srcSel == CMS_SRC_EXT)
    ) else $error("Mode 0 configuration wrong.");

    AST_MODE1_CFG: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_XTAL_X4) |->
            (crystalOscEn && shapingLoopEn && shapingLoopMult == `CMS_FACTOR_4)
    ) else $error("Mode 1 configuration wrong.");

    AST_MODE2_CFG: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_BUS_INPUT) |->
            (!busClockPinOe && !shapingLoopEn && mainLoopEn && srcSel == CMS_SRC_BUS)
    ) else $error("Mode 2 configuration wrong.");

    AST_BUS_DRIVE: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode != `CMS_MODE_BUS_INPUT) ##1 modeValid |-> busClockPinOe
    ) else $error("Bus clock pin not driven.");

    AST_LOOP_RESET_OFF: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        seqLatch |-> (loopFixedOn(clockMode) == mainLoopEn)
    ) else $error("Main loop wrong after mode latch.");

    AST_MODE3_CFG: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_XTAL_X1) |->
            (crystalOscEn && shapingLoopEn && shapingLoopMult == `CMS_FACTOR_1)
    ) else $error("Mode 3 configuration wrong.");

    AST_MODE5_CFG: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_EXT_HALF) |-> (halfDivEn && !shapingLoopEn)
    ) else $error("Mode 5 configuration wrong.");

    AST_RTC_HIGH: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_RTC_HIGH) |->
            (rtcLoopEn && rtcLoopTargetHz == `CMS_RTC_HIGH_HZ)
    ) else $error("Mode 6 loop target wrong.");

    AST_RTC_LOW: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && clockMode == `CMS_MODE_RTC_LOW) |->
            (rtcLoopEn && rtcLoopTargetHz == `CMS_RTC_LOW_HZ)
    ) else $error("Mode 7 loop target wrong.");

    AST_DIV_SOURCE: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (modeValid && !loopFixedOn(clockMode)) |-> (coreDivSrcLoop == mainLoopEn && !periphDivSrcLoop)
    ) else $error("Divider source wrong.");

    AST_LOOP_MULT: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state_r == CMS_ST_RUN && mainLoopMultSel == `CMS_CODE_X4 &&
            (loopFixedOn(mode_r) || mainLoopOnReq)) |=> (mainLoopMult == `CMS_FACTOR_4)
    ) else $error("Main loop factor wrong.");

    AST_DIV_FLOOR: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        mainLoopEn |-> (factorOf(coreDivRatio) <= mainLoopMult)
    ) else $error("Core clock below bus clock.");

endmodule // clock_mode_source_select

`default_nettype wire

// [verification/cms_board_clk.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Board clock sources and the bus clock pin wire
// ----------------------------------------------------------------------------
module cms_board_clk (
    input  wire logic clk_sys,
    input  wire logic busOe,
    input  wire logic busOut,
    output logic      extPin,
    output logic      xtalPin,
    output logic      rtcPin,
    output logic      busPin
);
    int cnt = 0;

    // Each source gets its own period, so a wrong source choice shows up as a wrong rate.
    always @(posedge clk_sys) cnt <= cnt + 1;

    // The external clock is twice the bus rate wanted in the half-rate mode.
    assign extPin  = (cnt % 8) < 4;
    assign xtalPin = (cnt % 12) < 6;
    assign rtcPin  = (cnt % 20) < 10;

    // The device wins the wire while it drives; otherwise the board clock is seen.
    assign busPin  = busOe ? busOut : ((cnt % 10) < 5);
endmodule // cms_board_clk

`default_nettype wire

// [verification/clock_mode_source_select_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module clock_mode_source_select_bench;
    import cms_pkg::*;

    // Expected configuration of one mode; en is xtal, shaping, rtc, half, main, drive.
    typedef struct {
        logic [2:0]  src;
        logic [5:0]  en;
        logic [2:0]  sm;
        logic [23:0] hz;
        int          rises;
    } cms_row_type;

    logic        clk_sys = 1'b0;
    logic        arst_n  = 1'b0;
    logic [2:0]  straps  = 3'h0;
    logic        req     = 1'b0;
    logic [1:0]  multSel = 2'h0;
    logic [1:0]  divSel  = 2'h0;
    logic        ext, xtal, rtc, busIn, out, oe, valid, xEn, sEn, rEn, hEn, mEn;
    logic        coreLoop, perLoop, prevOut, lvl, prevLvl;
    logic [2:0]  mode, src, sMult, mMult;
    logic [1:0]  ratio;
    logic [23:0] hz;
    int          err_total   = 0;
    int          checks_done = 0;
    int          nOut        = 0;
    int          nLvl        = 0;
    int          nBase, lBase;
    cms_row_type rows [8];

    always #5 clk_sys = ~clk_sys;

    clock_mode_source_select DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .clockModeStraps(straps),
        .extClockInPin(ext), .crystalClkIn(xtal), .rtcLoopClkIn(rtc),
        .busClockPinIn(busIn), .busClockPinOut(out), .busClockPinOe(oe),
        .mainLoopOnReq(req), .mainLoopMultSel(multSel), .coreDivSel(divSel),
        .modeValid(valid), .clockMode(mode), .srcSel(src), .crystalOscEn(xEn),
        .shapingLoopEn(sEn), .shapingLoopMult(sMult), .rtcLoopEn(rEn),
        .rtcLoopTargetHz(hz), .halfDivEn(hEn), .mainLoopEn(mEn), .mainLoopMult(mMult),
        .coreDivRatio(ratio), .coreDivSrcLoop(coreLoop), .periphDivSrcLoop(perLoop),
        .srcClkLevel(lvl)
    );

    cms_board_clk BOARD (
        .clk_sys(clk_sys), .busOe(oe), .busOut(out), .extPin(ext),
        .xtalPin(xtal), .rtcPin(rtc), .busPin(busIn)
    );

    // Rising edges on the bus pin are counted to measure its rate.
    always @(posedge clk_sys) begin
        if (out === 1'b1 && prevOut === 1'b0)
            nOut <= nOut + 1;
        if (lvl === 1'b1 && prevLvl === 1'b0)
            nLvl <= nLvl + 1;
        prevOut <= out;
        prevLvl <= lvl;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Power-on reset with the given straps; valid, oe, out and mEn must be off while reset is held.
    task automatic boot(input logic [2:0] m);
        @(negedge clk_sys);
        arst_n = 1'b0;
        straps = m;
        repeat (6) @(negedge clk_sys);
        chk({valid, oe, out, mEn}, 24'h0);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    // Watchdog sized well above the roughly 2200 cycles the sequence needs.
    initial begin
        #200000;
        err_total++;
        results();
    end

    initial begin
        rows = '{'{CMS_SRC_EXT, 6'h13, 3'h1, 24'h0, 30}, '{CMS_SRC_XTAL, 6'h33, 3'h4, 24'h0, 20},
                 '{CMS_SRC_BUS, 6'h02, 3'h0, 24'h0, 0}, '{CMS_SRC_XTAL, 6'h31, 3'h1, 24'h0, 20},
                 '{CMS_SRC_EXT, 6'h11, 3'h1, 24'h0, 30}, '{CMS_SRC_EXT, 6'h05, 3'h0, 24'h0, 15},
                 '{CMS_SRC_RTC, 6'h09, 3'h0, 24'he10000, 12},
                 '{CMS_SRC_RTC, 6'h09, 3'h0, 24'ha90010, 12}};
        for (int m = 0; m < 8; m++) begin
            boot(3'(m));
            chk({valid, mode}, {1'b1, 3'(m)});
            chk(src, rows[m].src);
            chk({xEn, sEn, rEn, hEn, mEn, oe}, rows[m].en);
            if (rows[m].sm != 3'h0)
                chk(sMult, rows[m].sm);
            chk(hz, rows[m].hz);
            chk({coreLoop, perLoop, mMult}, {rows[m].en[1], rows[m].en[1], 3'h1});
            // Give the loops a moment to settle before the rate is measured.
            repeat (20) @(negedge clk_sys);
            nBase = nOut;
            lBase = nLvl;
            repeat (240) @(negedge clk_sys);
            chk(24'((nOut - nBase - rows[m].rises) inside {[-1:1]}), 24'h1);
            // In mode 2 the source is the board clock on the bus pin, period 10.
            chk(24'((nLvl - lBase - ((m == 2) ? 24 : rows[m].rises)) inside {[-1:1]}), 24'h1);
            if (rows[m].en[0] == 1'b0)
                chk(out, 24'h0);
        end
        // Straps changed after the latch are ignored; software then runs the loop.
        boot(3'h3);
        straps = 3'h0;
        req = 1'b1;
        multSel = 2'h2;
        divSel = 2'h2;
        repeat (2) @(negedge clk_sys);
        chk(mode, 24'h3);
        chk({mEn, coreLoop, perLoop, mMult, ratio}, {3'b110, 3'h4, 2'h2});
        multSel = 2'h1;
        @(negedge clk_sys);
        chk({mMult, ratio}, {3'h2, 2'h1});
        req = 1'b0;
        @(negedge clk_sys);
        chk({mEn, coreLoop, mMult}, {2'b00, 3'h1});
        results();
    end
endmodule // clock_mode_source_select_bench

`default_nettype wire
